// *** common/haptic_pkg.sv ***
// shared offsets, fields, reset values and timing for the haptic drive control block
package haptic_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_MODE    = 8'h01;
  localparam logic [7:0] ADDR_PLAY    = 8'h02;
  localparam logic [7:0] ADDR_LAUNCH  = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL   = 8'h16;
  localparam logic [7:0] ADDR_FBCTL   = 8'h1A;
  localparam logic [7:0] ADDR_TIMING  = 8'h1C;
  localparam logic [7:0] ADDR_LOOPCTL = 8'h1D;
  localparam logic [7:0] ADDR_FUSE    = 8'h1E;
  localparam int         CFG_WORDS    = 5;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int STS_DIAG_BIT    = 3;
  localparam int MODE_RESET_BIT  = 7;
  localparam int MODE_STBY_BIT   = 6;
  localparam int FB_TYPE_BIT     = 7;
  localparam int FB_BRAKE_LSB    = 4;
  localparam int FB_GAIN_LSB     = 2;
  localparam int LOOP_BIDIR_BIT  = 7;
  localparam int LOOP_ERMOL_BIT  = 5;
  localparam int LOOP_FMT_BIT    = 3;
  localparam int LOOP_LRAOL_BIT  = 0;
  localparam int FUSE_TRIG_BIT   = 0;
  localparam int FUSE_DONE_BIT   = 2;
  localparam int FUSE_DUR_LSB    = 4;
  localparam int CFG_LEVEL       = 0;
  localparam int CFG_ODLIM       = 1;
  localparam int CFG_COMP        = 2;
  localparam int CFG_EMF         = 3;
  localparam int CFG_FB          = 4;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] RST_MODE    = 8'h40;
  localparam logic [7:0] RST_LOOPCTL = 8'h80;
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] RST_TIMING  = 8'h00;
  localparam logic [2:0] DEVICE_ID   = 3'h5; // arbitrary value
  localparam logic [2:0] MODE_PLAY   = 3'h5;
  localparam logic [2:0] MODE_AUTOCAL = 3'h7;
  localparam logic [7:0] MID_SCALE   = 8'h80;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_UNIT_NS   = 250000;

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cal_state_t;
endpackage

// *** rtl/haptic_drive_calibration_control.sv ***
// haptic drive control: loop modes, auto-calibration, one-time fuse store
//
// Operation
// - closed loop tracks level and resonant frequency
// - rotating type ignores resonant-only calibration inputs
// - calibration end overwrites result registers
// - writing 0x07 leaves standby, selects calibration
// - launch bit starts calibration, self-clears
// - fault flag reports calibration outcome
// - registers kept in standby, enable low
// - fuse accepts exactly one programming
// - fuse trigger copies config words to fuse
// - burned flag reads one until the power-on reset
// - soft reset reloads fused values; power reset loads 0x00
// - three drive modes, both actuator types
// - open loop scales to limit, signed
// - negative drive reverses or flips phase
// - eight-bit samples, signed or unsigned format
// - unidirectional maps full range, auto brake
// - steady level full scale, never above limit
// - closed loop brakes from back-emf comparison
// - bidirectional floors below mid-scale, power-up default
// - playback mode follows amplitude register
`timescale 1ns/1ps
module haptic_drive_calibration_control #(
  parameter int CAL_UNIT_CYCLES = haptic_pkg::CAL_UNIT_NS / haptic_pkg::CLK_PERIOD_NS
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       enablePin,
  input  wire logic       zeroCrossPin,
  input  wire logic [7:0] backEmf,
  output logic      [7:0] driveLevel,
  output logic            driveReverse,
  output logic            commutationPhase,
  output logic            driveOn
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] enSync_q;
  logic [1:0] zcSync_q;
  logic       zcPrev_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enSync_q <= 2'h0;
      zcSync_q <= 2'h0;
      zcPrev_q <= 1'b0;
    end else begin
      enSync_q <= {enSync_q[0], enablePin};
      zcSync_q <= {zcSync_q[0], zeroCrossPin};
      zcPrev_q <= zcSync_q[1];
    end
  end
  wire logic enabled  = enSync_q[1];
  wire logic zcRise   = zcSync_q[1] & ~zcPrev_q;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] cfg_q [0:haptic_pkg::CFG_WORDS-1];
  logic [7:0] fuse_q [0:haptic_pkg::CFG_WORDS-1];
  logic [7:0] mode_q;
  logic [7:0] playAmp_q;
  logic [7:0] timing_q;
  logic [7:0] loopCtl_q;
  logic [1:0] calDur_q;
  logic       go_q;
  logic       diag_q;
  logic       fuseBurned_q;
  haptic_pkg::cal_state_t calState_q;
  logic [19:0] calCnt_q;
  logic [7:0]  emfLast_q;

  wire logic [2:0] opMode    = mode_q[2:0];
  wire logic       standby   = mode_q[haptic_pkg::MODE_STBY_BIT];
  wire logic       isLra     = cfg_q[haptic_pkg::CFG_FB][haptic_pkg::FB_TYPE_BIT];
  wire logic [7:0] odLimit   = cfg_q[haptic_pkg::CFG_ODLIM];
  wire logic [7:0] steady    = cfg_q[haptic_pkg::CFG_LEVEL];
  wire logic [2:0] brakeGain = cfg_q[haptic_pkg::CFG_FB][haptic_pkg::FB_BRAKE_LSB +: 3];
  wire logic [1:0] loopGain  = cfg_q[haptic_pkg::CFG_FB][haptic_pkg::FB_GAIN_LSB +: 2];

  wire logic wrMode   = regWrite && (regAddr == haptic_pkg::ADDR_MODE);
  wire logic softRst  = wrMode && regWrData[haptic_pkg::MODE_RESET_BIT];
  wire logic goWrite  = regWrite && (regAddr == haptic_pkg::ADDR_LAUNCH) && regWrData[0];
  wire logic burnReq  = regWrite && (regAddr == haptic_pkg::ADDR_FUSE)
                        && regWrData[haptic_pkg::FUSE_TRIG_BIT];
  wire logic calDone  = (calState_q == haptic_pkg::CAL_DONE);

  // ------------------------------------------------------------
  // calibration results
  // ------------------------------------------------------------
  // timing inputs only matter for the resonant type
  wire logic [7:0] lraAdj  = isLra ? {2'h0, timing_q[5:0]} : 8'h00;
  wire logic [7:0] compRes = steady - (emfLast_q >> loopGain) - lraAdj;
  wire logic       calFault = (emfLast_q == 8'h00) || (emfLast_q > odLimit);
  wire logic [19:0] calLimit = 20'(CAL_UNIT_CYCLES * (int'(calDur_q) + 1));

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // plain registers: standby and enable low touch none of them
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < haptic_pkg::CFG_WORDS; i++) begin
        cfg_q[i] <= haptic_pkg::RST_CFG;
      end
      mode_q    <= haptic_pkg::RST_MODE;
      playAmp_q <= 8'h00;
      timing_q  <= haptic_pkg::RST_TIMING;
      loopCtl_q <= haptic_pkg::RST_LOOPCTL;
      calDur_q  <= 2'h0;
    end else if (softRst) begin
      for (int i = 0; i < haptic_pkg::CFG_WORDS; i++) begin
        cfg_q[i] <= fuseBurned_q ? fuse_q[i] : haptic_pkg::RST_CFG;
      end
      mode_q    <= haptic_pkg::RST_MODE;
      playAmp_q <= 8'h00;
      timing_q  <= haptic_pkg::RST_TIMING;
      loopCtl_q <= haptic_pkg::RST_LOOPCTL;
      calDur_q  <= 2'h0;
    end else begin
      if (regWrite) begin
        if (regAddr == haptic_pkg::ADDR_MODE) begin
          mode_q <= {1'b0, regWrData[6:0]};
        end else if (regAddr == haptic_pkg::ADDR_PLAY) begin
          playAmp_q <= regWrData;
        end else if (regAddr >= haptic_pkg::ADDR_LEVEL && regAddr <= haptic_pkg::ADDR_FBCTL) begin
          cfg_q[3'(regAddr - haptic_pkg::ADDR_LEVEL)] <= regWrData;
        end else if (regAddr == haptic_pkg::ADDR_TIMING) begin
          timing_q <= regWrData;
        end else if (regAddr == haptic_pkg::ADDR_LOOPCTL) begin
          loopCtl_q <= regWrData;
        end else if (regAddr == haptic_pkg::ADDR_FUSE) begin
          calDur_q <= regWrData[haptic_pkg::FUSE_DUR_LSB +: 2];
        end
      end
      // results land after any same-cycle bus write except a soft reset, which drops them
      if (calDone) begin
        cfg_q[haptic_pkg::CFG_COMP]      <= compRes;
        cfg_q[haptic_pkg::CFG_EMF]       <= emfLast_q;
        cfg_q[haptic_pkg::CFG_FB][1:0]   <= emfLast_q[7:6];
      end
    end
  end

  // ------------------------------------------------------------
  // calibration sequence
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      calState_q <= haptic_pkg::CAL_IDLE;
      calCnt_q   <= 20'h0;
      emfLast_q  <= 8'h00;
    end else begin
      case (calState_q)
        haptic_pkg::CAL_IDLE: begin
          calCnt_q <= 20'h0;
          if (go_q && opMode == haptic_pkg::MODE_AUTOCAL && !standby && enabled) begin
            calState_q <= haptic_pkg::CAL_RUN;
          end
        end
        haptic_pkg::CAL_RUN: begin
          calCnt_q  <= calCnt_q + 20'h1;
          emfLast_q <= backEmf;
          if (softRst) begin
            calState_q <= haptic_pkg::CAL_IDLE;
          end else if (calCnt_q >= calLimit - 20'h1) begin
            calState_q <= haptic_pkg::CAL_DONE;
          end
        end
        default: begin
          calState_q <= haptic_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  // set by software wins over the self-clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      go_q <= 1'b0;
    end else if (goWrite && !softRst) begin
      go_q <= 1'b1;
    end else if (softRst || calDone) begin
      go_q <= 1'b0;
    end else if (calState_q == haptic_pkg::CAL_IDLE && opMode != haptic_pkg::MODE_AUTOCAL) begin
      go_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      diag_q <= 1'b0;
    end else if (calDone) begin
      diag_q <= calFault;
    end else if (calState_q == haptic_pkg::CAL_RUN && calCnt_q == 20'h0) begin
      diag_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // one-time fuse store
  // ------------------------------------------------------------
  // nonvolatile in silicon; here cleared only by the power-on reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fuseBurned_q <= 1'b0;
    end else if (burnReq) begin
      fuseBurned_q <= 1'b1;
    end
  end

  generate
    for (genvar w = 0; w < haptic_pkg::CFG_WORDS; w++) begin : g_fuse
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          fuse_q[w] <= haptic_pkg::RST_CFG;
        end else if (burnReq && !fuseBurned_q) begin
          fuse_q[w] <= cfg_q[w];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (!regRead) begin
      regRdData <= 8'h00;
    end else if (regAddr == haptic_pkg::ADDR_STATUS) begin
      regRdData <= {haptic_pkg::DEVICE_ID, 1'b0, diag_q, 3'h0};
    end else if (regAddr == haptic_pkg::ADDR_MODE) begin
      regRdData <= mode_q;
    end else if (regAddr == haptic_pkg::ADDR_PLAY) begin
      regRdData <= playAmp_q;
    end else if (regAddr == haptic_pkg::ADDR_LAUNCH) begin
      regRdData <= {7'h00, go_q};
    end else if (regAddr >= haptic_pkg::ADDR_LEVEL && regAddr <= haptic_pkg::ADDR_FBCTL) begin
      regRdData <= cfg_q[3'(regAddr - haptic_pkg::ADDR_LEVEL)];
    end else if (regAddr == haptic_pkg::ADDR_TIMING) begin
      regRdData <= timing_q;
    end else if (regAddr == haptic_pkg::ADDR_LOOPCTL) begin
      regRdData <= loopCtl_q;
    end else if (regAddr == haptic_pkg::ADDR_FUSE) begin
      regRdData <= {2'h0, calDur_q, 1'b0, fuseBurned_q, 2'h0};
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // resonance tracking
  // ------------------------------------------------------------
  logic [15:0] periodCnt_q;
  logic [15:0] halfPeriod_q;
  logic [15:0] phaseCnt_q;
  logic        phase_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      periodCnt_q  <= 16'h0;
      halfPeriod_q <= 16'hFFFF;
      phaseCnt_q   <= 16'h0;
      phase_q      <= 1'b0;
    end else begin
      if (zcRise) begin
        periodCnt_q  <= 16'h0;
        halfPeriod_q <= {1'b0, periodCnt_q[15:1]};
      end else if (periodCnt_q != 16'hFFFF) begin
        periodCnt_q <= periodCnt_q + 16'h1;
      end
      if (zcRise || phaseCnt_q >= halfPeriod_q) begin
        phaseCnt_q <= 16'h0;
        phase_q    <= zcRise ? 1'b0 : ~phase_q;
      end else begin
        phaseCnt_q <= phaseCnt_q + 16'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // drive shaping
  // ------------------------------------------------------------
  wire logic openLoop = isLra ? loopCtl_q[haptic_pkg::LOOP_LRAOL_BIT]
                              : loopCtl_q[haptic_pkg::LOOP_ERMOL_BIT];
  wire logic bidir    = loopCtl_q[haptic_pkg::LOOP_BIDIR_BIT];
  // signed samples become offset binary around mid-scale
  wire logic [7:0] sampleOff = loopCtl_q[haptic_pkg::LOOP_FMT_BIT] ? playAmp_q
                                                                  : playAmp_q ^ haptic_pkg::MID_SCALE;
  wire logic playing  = enabled && !standby && opMode == haptic_pkg::MODE_PLAY;
  wire logic calibrating = enabled && calState_q == haptic_pkg::CAL_RUN;

  logic [15:0] olMag;
  logic [15:0] target;
  logic [15:0] mag;
  logic [15:0] nextLevel;
  logic        nextNeg;
  always_comb begin
    olMag     = 16'h0;
    target    = 16'h0;
    mag       = 16'h0;
    nextNeg   = 1'b0;
    nextLevel = 16'h0;
    if (openLoop) begin
      // mid-scale gives no drive; below gives negative drive
      if (sampleOff >= haptic_pkg::MID_SCALE) begin
        olMag = {8'h0, sampleOff - haptic_pkg::MID_SCALE};
      end else begin
        olMag   = {8'h0, haptic_pkg::MID_SCALE - sampleOff};
        nextNeg = 1'b1;
      end
      mag = (olMag * {8'h0, odLimit}) >> 7;
    end else begin
      if (!bidir) begin
        target = ({8'h0, sampleOff} * {8'h0, steady} + {8'h0, steady}) >> 8;
      end else if (sampleOff > haptic_pkg::MID_SCALE) begin
        target = ({8'h0, sampleOff - haptic_pkg::MID_SCALE} * {8'h0, steady} + {8'h0, steady}) >> 7;
      end else begin
        target = 16'h0;
      end
      if ({8'h0, backEmf} > target) begin
        nextNeg = 1'b1;
        mag     = ({8'h0, backEmf} - target) << brakeGain;
      end else begin
        mag = target + (({8'h0, backEmf} ^ 16'h00FF) & target) >> (3'h3 - {1'b0, loopGain});
      end
    end
    if (calibrating) begin
      mag     = {8'h0, steady};
      nextNeg = 1'b0;
    end
    nextLevel = (mag > {8'h0, odLimit}) ? {8'h0, odLimit} : mag;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      driveLevel       <= 8'h00;
      driveReverse     <= 1'b0;
      commutationPhase <= 1'b0;
      driveOn          <= 1'b0;
    end else if (playing || calibrating) begin
      driveLevel       <= nextLevel[7:0];
      driveReverse     <= nextNeg && !isLra;
      commutationPhase <= isLra && (phase_q ^ nextNeg);
      driveOn          <= 1'b1;
    end else begin
      driveLevel       <= 8'h00;
      driveReverse     <= 1'b0;
      commutationPhase <= 1'b0;
      driveOn          <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_launch_clear: assert property (calDone && !goWrite |=> !go_q)
    else $error("launch bit not cleared after calibration");
  a_launch_busy: assert property (calState_q == haptic_pkg::CAL_RUN |-> go_q)
    else $error("launch bit low while calibrating");
  a_result_write: assert property (calDone && !softRst |=> cfg_q[haptic_pkg::CFG_COMP] == $past(compRes))
    else $error("calibration result not written");
  a_diag_report: assert property (calDone |=> diag_q == $past(calFault))
    else $error("fault flag does not match outcome");
  a_fuse_once: assert property (fuseBurned_q |=> fuse_q[1] == $past(fuse_q[1]) && fuse_q[0] == $past(fuse_q[0]))
    else $error("fuse changed after programming");
  a_fuse_copy: assert property (burnReq && !fuseBurned_q |=> fuse_q[4] == $past(cfg_q[4]))
    else $error("fuse did not copy configuration");
  a_fuse_flag: assert property (burnReq |=> fuseBurned_q [*8])
    else $error("burned flag dropped");
  a_fuse_reload: assert property (softRst && fuseBurned_q |=> cfg_q[1] == $past(fuse_q[1]))
    else $error("fused value not reloaded");
  a_drive_clamp: assert property (driveOn |-> driveLevel <= $past(odLimit))
    else $error("drive above overdrive limit");
  a_bidir_floor: assert property (playing && !openLoop && bidir && sampleOff <= haptic_pkg::MID_SCALE
                                  && backEmf == 8'h00 |=> driveLevel == 8'h00)
    else $error("bidirectional drive below mid-scale");
  a_standby_idle: assert property (standby && !calibrating |=> !driveOn)
    else $error("drive active in standby");

  c_cal_done: cover property (calState_q == haptic_pkg::CAL_RUN ##1 calDone);
  c_fuse_burn: cover property (burnReq && !fuseBurned_q);
  c_brake: cover property (playing && !openLoop && nextNeg);
  c_play_open: cover property (playing && openLoop ##1 driveOn);
endmodule // haptic_drive_calibration_control

// *** verif/host_model.sv ***
// host-side bus master model for the haptic drive control block
`timescale 1ns/1ps
module host_model (
  input  wire logic       clock,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWrite,
  output logic            regRead
);
  logic [7:0] expQ[$];

  initial begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
  end

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // strobes stay high across back-to-back calls; cyc lowers them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    regRead   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr  <= a;
    regWrite <= 1'b0;
    regRead  <= 1'b1;
    expQ.push_back(e);
  endtask

  // idle data lines toggle so a stale value never looks valid
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clock);
      regWrite  <= 1'b0;
      regRead   <= 1'b0;
      regWrData <= ~regWrData;
    end
  endtask

  // ------------------------------------------------------------
  // configuration sequences
  // ------------------------------------------------------------
  task automatic openLoop(input logic resonant);
    wr(8'h1A, {resonant, 7'h28});
    wr(8'h1D, resonant ? 8'h09 : 8'h28);
  endtask

  task automatic closedLoop(input logic bidir);
    wr(8'h1D, bidir ? 8'h88 : 8'h08);
  endtask

  task automatic calSetup(input logic [7:0] timing);
    wr(8'h01, 8'h07);
    wr(8'h1A, 8'h28);
    wr(8'h1C, timing);
    wr(8'h1E, 8'h30);
    wr(8'h0C, 8'h01);
  endtask

  task automatic fuseBurn();
    wr(8'h1E, 8'h01);
  endtask
endmodule // host_model

// *** verif/testbench.sv ***
// self-checking bench: register map, drive modes, calibration, fuse store
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin nErrors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
  localparam int UNIT = 4;
  logic       clock, nrst, enablePin, zeroCrossPin;
  logic       regWrite, regRead, driveReverse, commutationPhase, driveOn, rdPending;
  logic [7:0] regAddr, regWrData, backEmf, regRdData, driveLevel, expRd, emf;
  logic [7:0] cfg [5];
  int         nErrors, samplesChecked, cycles;

  host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
                   .regRead(regRead));
  haptic_drive_calibration_control #(.CAL_UNIT_CYCLES(UNIT)) dut (.clock(clock), .nrst(nrst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .enablePin(enablePin), .zeroCrossPin(zeroCrossPin), .backEmf(backEmf),
    .driveLevel(driveLevel), .driveReverse(driveReverse), .commutationPhase(commutationPhase),
    .driveOn(driveOn));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ------------------------------------------------------------
  // read-data scoreboard
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (rdPending) begin
      expRd = host.expQ.pop_front();
      `CHK("read data", expRd, regRdData)
    end
    rdPending <= regRead;
  end

  // hang guard; ceiling well above the few hundred cycles used
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nErrors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic play(input logic [7:0] amp, input logic rev, input logic ph, input logic zero);
    // zero-cross pulse pins the resonant phase low during the checks
    zeroCrossPin <= 1'b1;
    host.wr(8'h02, amp);
    zeroCrossPin <= 1'b0;
    host.cyc(4);
    `CHK("reverse", rev, driveReverse)
    `CHK("phase", ph, commutationPhase)
    `CHK("zero level", zero, driveLevel == 8'h00)
    `CHK("clamp", 1'b1, driveLevel <= 8'hC0)
    `CHK("drive on", 1'b1, driveOn)
  endtask

  initial begin
    nrst         = 1'b0;
    enablePin    = 1'b0;
    zeroCrossPin = 1'b0;
    backEmf      = 8'h40;
    rdPending    = 1'b0;
    cycles       = 0;
    void'($urandom(32'hF87EFE3E));
    repeat (5) @(posedge clock);
    nrst      <= 1'b1;
    enablePin <= 1'b1;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    host.rd(8'h01, 8'h40);
    host.rd(8'h1D, 8'h80);
    host.rd(8'h00, 8'hA0);
    host.rd(8'h1E, 8'h00);
    host.rd(8'h55, 8'h00);
    host.cyc(2);
    $display("test reset done");
    // retention with enable low in standby
    for (int i = 0; i < 5; i++) begin
      cfg[i] = 8'($urandom);
      host.wr(8'(8'h16 + i), cfg[i]);
    end
    enablePin <= 1'b0;
    backEmf   <= 8'($urandom);
    host.cyc(4);
    for (int i = 0; i < 5; i++)
      host.rd(8'(8'h16 + i), cfg[i]);
    enablePin <= 1'b1;
    host.cyc(2);
    $display("test retention done");
    // ------------------------------------------------------------
    // open loop, both actuator types
    // ------------------------------------------------------------
    host.wr(8'h16, 8'h90);
    host.wr(8'h17, 8'hC0);
    host.wr(8'h01, 8'h05);
    host.openLoop(1'b0);
    play(8'h80, 1'b0, 1'b0, 1'b1);
    play(8'h00, 1'b1, 1'b0, 1'b0);
    play(8'hFF, 1'b0, 1'b0, 1'b0);
    host.openLoop(1'b1);
    play(8'h00, 1'b0, 1'b1, 1'b0);
    host.wr(8'h1D, 8'h01);
    play(8'hFF, 1'b0, 1'b1, 1'b0);
    play(8'h7F, 1'b0, 1'b0, 1'b0);
    $display("test open loop done");
    // ------------------------------------------------------------
    // closed loop
    // ------------------------------------------------------------
    host.wr(8'h1A, 8'h28);
    backEmf <= 8'h00;
    host.closedLoop(1'b1);
    play(8'h10, 1'b0, 1'b0, 1'b1);
    play(8'hFF, 1'b0, 1'b0, 1'b0);
    host.closedLoop(1'b0);
    play(8'h10, 1'b0, 1'b0, 1'b0);
    play(8'h00, 1'b0, 1'b0, 1'b1);
    backEmf <= 8'hF0;
    play(8'h00, 1'b1, 1'b0, 1'b0);
    $display("test closed loop done");
    // ------------------------------------------------------------
    // calibration: two clean runs, second without resonant inputs, then a fault
    // ------------------------------------------------------------
    host.wr(8'h16, 8'h60);
    host.wr(8'h17, 8'h90);
    for (int r = 0; r < 3; r++) begin
      // nonzero feedback at or below the limit is a clean run
      emf = (r == 2) ? 8'h00 : 8'(8'h01 + $urandom % 8'h8F);
      backEmf <= emf;
      host.calSetup((r == 0) ? 8'h35 : 8'h00);
      host.rd(8'h0C, 8'h01);
      host.cyc(3);
      `CHK("cal drive", 1'b1, driveOn)
      host.cyc(UNIT * 4 + 4);
      host.rd(8'h0C, 8'h00);
      host.rd(8'h00, (r == 2) ? 8'hA8 : 8'hA0);
      host.rd(8'h18, 8'(8'h60 - (emf >> 2)));
      host.rd(8'h19, emf);
      host.rd(8'h1A, {6'h0A, emf[7:6]});
    end
    host.cyc(2);
    $display("test calibration done");
    // ------------------------------------------------------------
    // one-time fuse store
    // ------------------------------------------------------------
    for (int i = 0; i < 5; i++)
      host.wr(8'(8'h16 + i), cfg[i]);
    host.fuseBurn();
    host.rd(8'h1E, 8'h04);
    host.wr(8'h16, ~cfg[0]);
    host.fuseBurn();
    host.wr(8'h01, 8'h80);
    host.cyc(2);
    for (int i = 0; i < 5; i++)
      host.rd(8'(8'h16 + i), cfg[i]);
    host.rd(8'h1E, 8'h04);
    host.rd(8'h01, 8'h40);
    host.cyc(3);
    $display("test fuse done");
    results();
  end
endmodule // testbench
